//--- include/bsf_consts.vh
// Constants for the boot sector flash host controller: offsets, fields, resets and timing.
`ifndef BSF_CONSTS_VH
`define BSF_CONSTS_VH
// Byte offsets of the controller's own registers.
`define BSF_OFS_CTRL 5'h00
`define BSF_OFS_ADDR 5'h04
`define BSF_OFS_WDATA 5'h08
`define BSF_OFS_STATUS 5'h0c
// Operation codes in the control register.
`define BSF_OP_READ 2'h0
`define BSF_OP_WRITE 2'h1
`define BSF_OP_POLL 2'h2
`define BSF_OP_RESET 2'h3
// Field positions.
`define BSF_CTRL_GO 2
`define BSF_STAT_BUSY 0
`define BSF_STAT_DONE 1
`define BSF_STAT_TMO 2
`define BSF_STAT_TOG 3
// Reset values.
`define BSF_ADDR_RST 17'h00000
`define BSF_DATA_RST 8'h00
// Flash geometry.
`define BSF_ARRAY_BYTES 131072
`define BSF_ADDR_W 17
// Timing in nanoseconds and the derived cycle counts.
`define BSF_CLK_NS 100
`define BSF_ACC_NS 90
`define BSF_WP_NS 100
`define BSF_RCV_NS 100
`define BSF_RST_NS 500
`define BSF_ACC_CYC ((`BSF_ACC_NS + `BSF_CLK_NS - 1) / `BSF_CLK_NS)
`define BSF_WP_CYC ((`BSF_WP_NS + `BSF_CLK_NS - 1) / `BSF_CLK_NS)
`define BSF_RCV_CYC ((`BSF_RCV_NS + `BSF_CLK_NS - 1) / `BSF_CLK_NS)
`define BSF_RST_CYC ((`BSF_RST_NS + `BSF_CLK_NS - 1) / `BSF_CLK_NS)
`define BSF_SYNC_CYC 2
`define BSF_POLL_LIMIT 16'hffff
`endif

//--- rtl/bsf_flash_host.v
// Host controller that drives a byte-wide boot sector NOR flash from AXI4-Lite registers.
// Function
// - Three active-low controls, never contend data lines.
// - Commands are plain write cycles to flash.
// - Bypass mode programs with two writes, not four.
// - Busy reads show inverted bit7, toggling bit6.
// - Host may deselect the device for standby.
`timescale 1ns/100ps
`default_nettype none
`include "bsf_consts.vh"
module bsf_flash_host #(
  parameter [15:0] POLL_LIMIT = `BSF_POLL_LIMIT
) (
  // Clock and reset.
  input wire core_clk,
  input wire resetn,
  // AXI4-Lite write address channel.
  input wire [4:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data channel.
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response channel.
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address channel.
  input wire [4:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data channel.
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Flash bus pins.
  output reg [16:0] flashAddr,
  input wire [7:0] byteDataLinesIn,
  output reg [7:0] byteDataLinesOut,
  output reg byteDataLinesOe,
  output reg flashCeN,
  output reg flashWeN,
  output reg flashOeN,
  output reg flashResetN
);

  // Cycle counts derived from the nanosecond figures.
  // The integer forms are cut to the counter width on purpose.
  localparam integer ACC_I = `BSF_ACC_CYC;
  localparam integer WP_I = `BSF_WP_CYC;
  localparam integer RCV_I = `BSF_RCV_CYC;
  localparam integer RST_I = `BSF_RST_CYC;
  localparam integer SYNC_I = `BSF_SYNC_CYC;
  localparam [7:0] ACC_CYC = ACC_I[7:0];
  localparam [7:0] WP_CYC = WP_I[7:0];
  localparam [7:0] RCV_CYC = RCV_I[7:0];
  localparam [7:0] RST_CYC = RST_I[7:0];
  localparam [7:0] SYNC_CYC = SYNC_I[7:0];
  // Bus sequencer states.
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WSET = 3'h1;
  localparam [2:0] ST_WPUL = 3'h2;
  localparam [2:0] ST_RDWT = 3'h3;
  localparam [2:0] ST_RECV = 3'h4;
  localparam [2:0] ST_RSTL = 3'h5;
  localparam [2:0] ST_RSTR = 3'h6;

  // Register index decode, shared by the read and write paths.
  function [2:0] regSel;
    input [4:0] ofs;
    begin
      case (ofs)
        `BSF_OFS_CTRL: regSel = 3'h1;
        `BSF_OFS_ADDR: regSel = 3'h2;
        `BSF_OFS_WDATA: regSel = 3'h3;
        `BSF_OFS_STATUS: regSel = 3'h4;
        default: regSel = 3'h0;
      endcase
    end
  endfunction

  // Byte lane merge under the write strobes.
  function [31:0] laneMerge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      laneMerge = old;
      for (i = 0; i < 4; i = i + 1)
        if (strb[i])
          laneMerge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // Write channel holding state; address and data may arrive in either order.
  reg awHave_q;
  reg wHave_q;
  reg [4:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  // Software visible registers.
  reg [1:0] op_q;
  reg [16:0] addr_q;
  reg [7:0] wByte_q;
  reg busy_q;
  reg done_q;
  reg tmo_q;
  reg tog_q;
  reg [7:0] rdByte_q;
  // Sequencer internals.
  reg [2:0] state_q;
  reg [7:0] cnt_q;
  reg pollSecond_q;
  reg [15:0] pollCnt_q;
  reg finish_q;
  // Data pin synchroniser; only the second stage is read by logic.
  reg [7:0] syncA_q;
  reg [7:0] syncB_q;

  // Combinational decode of the write in flight.
  wire wrFire = awHave_q && wHave_q && !s_axi_bvalid;
  wire [2:0] wrSel = regSel(awAddr_q);
  wire [31:0] ctrlMerged = laneMerge({29'h0, 1'b0, op_q}, wData_q, wStrb_q);
  wire goWrite = wrFire && (wrSel == 3'h1) && ctrlMerged[`BSF_CTRL_GO] && !busy_q;
  wire doneClear = wrFire && (wrSel == 3'h4) && wStrb_q[0] && wData_q[`BSF_STAT_DONE];
  wire [31:0] statusWord = {16'h0, rdByte_q, 4'h0, tog_q, tmo_q, done_q, busy_q};
  // Strobe-merged images of the address and data registers.
  wire [31:0] addrMerged = laneMerge({15'h0, addr_q}, wData_q, wStrb_q);
  wire [31:0] byteMerged = laneMerge({24'h0, wByte_q}, wData_q, wStrb_q);

  // Two flops on the data pins, since the flash drives them without our clock.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      syncA_q <= 8'h00;
      syncB_q <= 8'h00;
    end
    else
    begin
      syncA_q <= byteDataLinesIn;
      syncB_q <= syncA_q;
    end
  end

  // AXI write channels: accept each half once, answer after both are held.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awAddr_q <= 5'h00;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else
    begin
      // Ready is raised only while the slot is empty, so one write is held at a time.
      s_axi_awready <= !awHave_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHave_q && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHave_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHave_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (wrFire)
      begin
        // Unmapped offsets answer SLVERR and change nothing.
        awHave_q <= 1'b0;
        wHave_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wrSel == 3'h0) ? 2'h2 : 2'h0;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI read channel: answer in the cycle after the address is taken.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case (regSel(s_axi_araddr))
          3'h1: s_axi_rdata <= {30'h0, op_q};
          3'h2: s_axi_rdata <= {15'h0, addr_q};
          3'h3: s_axi_rdata <= {24'h0, wByte_q};
          3'h4: s_axi_rdata <= statusWord;
          default:
          begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration registers; they are frozen while an operation runs.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      op_q <= `BSF_OP_READ;
      addr_q <= `BSF_ADDR_RST;
      wByte_q <= `BSF_DATA_RST;
    end
    else if (wrFire && !busy_q)
    begin
      if (wrSel == 3'h1)
        op_q <= ctrlMerged[1:0];
      if (wrSel == 3'h2)
        addr_q <= addrMerged[16:0];
      if (wrSel == 3'h3)
        wByte_q <= byteMerged[7:0];
    end
  end

  // Done flag: the sequencer's set wins over a software clear in the same cycle.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      done_q <= 1'b0;
    else if (finish_q)
      done_q <= 1'b1;
    else if (doneClear || goWrite)
      done_q <= 1'b0;
  end

  // Flash bus sequencer: one bus cycle per command write, reads and polling loops.
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
      finish_q <= 1'b0;
      tmo_q <= 1'b0;
      rdByte_q <= 8'h00;
      pollSecond_q <= 1'b0;
      pollCnt_q <= 16'h0000;
      flashAddr <= 17'h00000;
      byteDataLinesOut <= 8'h00;
      byteDataLinesOe <= 1'b0;
      flashCeN <= 1'b1;
      flashWeN <= 1'b1;
      flashOeN <= 1'b1;
      flashResetN <= 1'b1;
    end
    else
    begin
      finish_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          // Idle leaves the chip deselected, which is its standby state.
          flashCeN <= 1'b1;
          byteDataLinesOe <= 1'b0;
          if (goWrite)
          begin
            busy_q <= 1'b1;
            tmo_q <= 1'b0;
            pollSecond_q <= 1'b0;
            pollCnt_q <= 16'h0000;
            // A new address each access also wakes the chip from sleep.
            flashAddr <= addr_q;
            case (ctrlMerged[1:0])
              `BSF_OP_WRITE:
              begin
                // Data is driven before the strobe and only with the outputs gated off.
                // Each write is one bus cycle, so bypass two-write programs need nothing more.
                flashCeN <= 1'b0;
                flashOeN <= 1'b1;
                byteDataLinesOut <= wByte_q;
                byteDataLinesOe <= 1'b1;
                state_q <= ST_WSET;
              end
              `BSF_OP_RESET:
              begin
                // Pulse the reset pin to abort any embedded operation.
                flashResetN <= 1'b0;
                cnt_q <= RST_CYC;
                state_q <= ST_RSTL;
              end
              default:
              begin
                flashCeN <= 1'b0;
                flashOeN <= 1'b0;
                cnt_q <= ACC_CYC + SYNC_CYC;
                state_q <= ST_RDWT;
              end
            endcase
          end
        end
        ST_WSET:
        begin
          // Lower the write strobe; the flash latches address and data when it rises again.
          flashWeN <= 1'b0;
          cnt_q <= WP_CYC;
          state_q <= ST_WPUL;
        end
        ST_WPUL:
        begin
          if (cnt_q <= 8'h01)
          begin
            flashWeN <= 1'b1;
            cnt_q <= RCV_CYC;
            state_q <= ST_RECV;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        end
        ST_RDWT:
        begin
          // Wait access time plus the synchroniser delay before sampling.
          if (cnt_q <= 8'h01)
          begin
            rdByte_q <= syncB_q;
            flashOeN <= 1'b1;
            flashCeN <= 1'b1;
            cnt_q <= RCV_CYC;
            state_q <= ST_RECV;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        end
        ST_RECV:
        begin
          // Recovery keeps data driven through hold, then releases the lines.
          if (cnt_q > 8'h01)
            cnt_q <= cnt_q - 8'h01;
          else if (op_q == `BSF_OP_POLL && (!pollSecond_q || (tog_q && pollCnt_q != POLL_LIMIT)))
          begin
            // Keep reading while bit 6 still toggles between reads.
            pollSecond_q <= 1'b1;
            pollCnt_q <= pollCnt_q + 16'h0001;
            flashCeN <= 1'b0;
            flashOeN <= 1'b0;
            cnt_q <= ACC_CYC + SYNC_CYC;
            state_q <= ST_RDWT;
          end
          else
          begin
            // A stable toggle bit means the device is back in read mode.
            tmo_q <= (op_q == `BSF_OP_POLL) && tog_q;
            byteDataLinesOe <= 1'b0;
            flashCeN <= 1'b1;
            busy_q <= 1'b0;
            finish_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_RSTL:
        begin
          if (cnt_q <= 8'h01)
          begin
            flashResetN <= 1'b1;
            cnt_q <= RST_CYC;
            state_q <= ST_RSTR;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        end
        ST_RSTR:
        begin
          if (cnt_q <= 8'h01)
          begin
            busy_q <= 1'b0;
            finish_q <= 1'b1;
            state_q <= ST_IDLE;
          end
          else
            cnt_q <= cnt_q - 8'h01;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Toggle detector: compare bit 6 of each new poll read with the one before.
  reg [7:0] prevByte_q;
  always @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      prevByte_q <= 8'h00;
      tog_q <= 1'b0;
    end
    else if (state_q == ST_RDWT && cnt_q <= 8'h01)
    begin
      prevByte_q <= syncB_q;
      tog_q <= pollSecond_q && (prevByte_q[6] != syncB_q[6]);
    end
    else if (goWrite)
      tog_q <= 1'b0;
  end

endmodule // bsf_flash_host
`default_nettype wire

//--- verif/bsf_flash_props.sv
// Checker for the flash host's pin timing and register bus answers.
`timescale 1ns/100ps
`default_nettype none
module bsf_flash_props (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic resetn,
  // Register bus handshakes.
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid,
  // Flash pins.
  input wire logic [16:0] flashAddr,
  input wire logic [7:0] byteDataLinesOut,
  input wire logic byteDataLinesOe, flashCeN, flashWeN, flashOeN, flashResetN
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // The reset pin is held low five cycles, then released.
  sequence rstPulse;
    !flashResetN [*5] ##1 flashResetN;
  endsequence
  // Address and data taken together on one edge.
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_we_with_ce: assert property ($fell(flashWeN) |-> !flashCeN)
    else $error("write strobe without chip select");
  a_no_contend: assert property (!flashOeN |-> !byteDataLinesOe)
    else $error("host drives data while output gate is low");
  a_wr_stable: assert property (!flashWeN |-> byteDataLinesOe && $stable(flashAddr) && $stable(byteDataLinesOut))
    else $error("address or data moved during write strobe");
  a_we_width: assert property ($fell(flashWeN) |=> flashWeN)
    else $error("write strobe not one cycle wide");
  a_rd_width: assert property ($fell(flashOeN) |-> !flashOeN [*3] ##1 flashOeN)
    else $error("output gate not three cycles wide");
  a_rst_width: assert property ($fell(flashResetN) |-> rstPulse)
    else $error("reset pin pulse not five cycles");
  a_b_follows: assert property (wrTaken |=> ##1 s_axi_bvalid)
    else $error("write response late");
  a_r_follows: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule // bsf_flash_props
bind bsf_flash_host bsf_flash_props u_props (.core_clk(core_clk), .resetn(resetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .flashAddr(flashAddr),
  .byteDataLinesOut(byteDataLinesOut), .byteDataLinesOe(byteDataLinesOe), .flashCeN(flashCeN),
  .flashWeN(flashWeN), .flashOeN(flashOeN), .flashResetN(flashResetN));
`default_nettype wire

//--- verif/bsf_flash_model.sv
// Behavioural byte-wide flash that answers the host controller's pins.
`timescale 1ns/100ps
`default_nettype none
module bsf_flash_model #(
  parameter logic [7:0] CMD_UNLK1 = 8'haa,
  parameter logic [7:0] CMD_UNLK2 = 8'h55,
  parameter logic [7:0] CMD_PROG = 8'ha0,
  parameter int PROG_NS = 20000
) (
  // Flash pins seen from the device.
  input wire logic [16:0] flashAddr,
  input wire logic [7:0] dataIn,
  input wire logic flashCeN, flashWeN, flashOeN, flashResetN,
  // Read data and its drive enable.
  output logic [7:0] dataOut,
  output logic dataDrive
);
  logic [7:0] mem [int]; // Sparse array; unwritten bytes read erased.
  logic [7:0] rdByte, pendByte;
  logic tog;
  int step;
  realtime doneAt;
  initial
  begin
    step = 0;
    doneAt = 0;
    {tog, rdByte, pendByte} = '0;
  end
  // Busy is time based because the real part has no clock.
  function automatic logic busy();
    return $realtime < doneAt;
  endfunction
  // Each write latches address and data and steps the command parser.
  always @(posedge flashWeN) if (!flashCeN && flashResetN && !busy())
  begin
    pendByte = dataIn;
    if (step == 3)
    begin
      mem[flashAddr] = (mem.exists(flashAddr) ? mem[flashAddr] : 8'hff) & dataIn;
      doneAt = $realtime + PROG_NS;
      step = 0;
    end
    else if (dataIn == (step == 0 ? CMD_UNLK1 : step == 1 ? CMD_UNLK2 : CMD_PROG)) step = step + 1;
    else step = 0;
  end
  // The reset pin drops any operation and returns to array reads.
  always @(negedge flashResetN)
  begin
    doneAt = 0;
    step = 0;
  end
  // Reads show status while busy, array contents otherwise.
  always @(negedge flashOeN or flashAddr)
  begin
    if (busy() && !flashOeN) tog = ~tog;
    rdByte = busy() ? {~pendByte[7], tog, pendByte[5:0]} : (mem.exists(flashAddr) ? mem[flashAddr] : 8'hff);
  end
  // A released bus shows the inverse so stale data never passes.
  assign dataDrive = !flashCeN && !flashOeN;
  assign dataOut = dataDrive ? rdByte : ~rdByte;
endmodule // bsf_flash_model
`default_nettype wire

//--- verif/tb.sv
// Self-checking bench for the flash host controller with a behavioural flash.
`timescale 1ns/100ps
`default_nettype none
`include "bsf_consts.vh"
module tb;
  logic core_clk, resetn; // Bench clock and reset.
  logic [4:0] awAddr, arAddr; // Register bus signals.
  logic [31:0] wData, rData, s, v;
  logic [1:0] bResp, rResp;
  logic awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  logic [16:0] fAddr, pa; // Flash pins and test values.
  logic [7:0] dOut, mOut, pd;
  wire logic [7:0] dIn;
  logic dOe, ceN, weN, oeN, rstN, mDrive;
  logic [65:0] expQ[$], e66; // Read expectations: response, mask, value.
  logic [1:0] expB[$]; // Write response expectations.
  int n_mismatch, compares, seed, cyc;
  // Nobody driving shows the inverse of the host's byte.
  assign dIn = mDrive ? mOut : (dOe ? dOut : ~dOut);
  bsf_flash_host #(.POLL_LIMIT(16'h0010)) dut (.core_clk(core_clk), .resetn(resetn),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .flashAddr(fAddr), .byteDataLinesIn(dIn), .byteDataLinesOut(dOut),
    .byteDataLinesOe(dOe), .flashCeN(ceN), .flashWeN(weN), .flashOeN(oeN), .flashResetN(rstN));
  bsf_flash_model flash (.flashAddr(fAddr), .dataIn(dOut), .flashCeN(ceN), .flashWeN(weN),
    .flashOeN(oeN), .flashResetN(rstN), .dataOut(mOut), .dataDrive(mDrive));
  initial
  begin
    core_clk = 0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Write master: both channels offered at once, released as each is taken.
  task automatic axiWrite(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge core_clk);
    expB.push_back(r);
    awAddr <= a; wData <= d; awValid <= 1; wValid <= 1; bReady <= 1;
    do
    begin
      @(posedge core_clk);
      if (awReady) awValid <= 0;
      if (wReady) wValid <= 0;
    end while (!(bValid && bReady));
    bReady <= 0;
  endtask
  // Read master; a zero mask checks the response only.
  task automatic axiRead(input logic [4:0] a, input logic [31:0] m, x, input logic [1:0] r, output logic [31:0] got);
    @(posedge core_clk);
    expQ.push_back({r, m, x});
    arAddr <= a; arValid <= 1; rReady <= 1;
    do
    begin
      @(posedge core_clk);
      if (arReady) arValid <= 0;
    end while (!(rValid && rReady));
    got = rData;
    rReady <= 0;
  endtask
  // Start one flash operation and wait till it is no longer busy.
  task automatic runOp(input logic [1:0] op, output logic [31:0] st);
    axiWrite(`BSF_OFS_CTRL, {29'h0, 1'b1, op}, 2'h0);
    do axiRead(`BSF_OFS_STATUS, 0, 0, 2'h0, st); while (st[0]);
    axiRead(`BSF_OFS_STATUS, 32'h3, 32'h2, 2'h0, st);
  endtask
  task automatic flashWr(input logic [16:0] a, input logic [7:0] d);
    axiWrite(`BSF_OFS_ADDR, {15'h0, a}, 2'h0);
    axiWrite(`BSF_OFS_WDATA, {24'h0, d}, 2'h0);
    runOp(`BSF_OP_WRITE, s);
  endtask
  task automatic flashRd(input logic [16:0] a, input logic [7:0] m, x);
    axiWrite(`BSF_OFS_ADDR, {15'h0, a}, 2'h0);
    runOp(`BSF_OP_READ, s);
    axiRead(`BSF_OFS_STATUS, {16'h0, m, 8'h0}, {16'h0, x, 8'h0}, 2'h0, s);
  endtask
  // Four-write program sequence.
  task automatic progSeq(input logic [16:0] a, input logic [7:0] d);
    flashWr(17'h00555, 8'haa);
    flashWr(17'h002aa, 8'h55);
    flashWr(17'h00555, 8'ha0);
    flashWr(a, d);
  endtask
  // Monitor: every answer is matched to the oldest expectation.
  always @(posedge core_clk)
  begin
    if (rValid && rReady)
    begin
      e66 = expQ.pop_front();
      check("read resp", {30'h0, rResp}, {30'h0, e66[65:64]});
      if (e66[63:32] != 0) check("read data", rData & e66[63:32], e66[31:0]);
    end
    if (bValid && bReady) check("write resp", {30'h0, bResp}, {30'h0, expB.pop_front()});
  end
  // Hang guard.
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  initial
  begin
    {n_mismatch, compares, cyc} = 0;
    seed = 32'h6ea0;
    {resetn, awAddr, arAddr, wData, awValid, wValid, bReady, arValid, rReady} = 0;
    repeat (20) @(posedge core_clk);
    resetn <= 1;
    @(posedge core_clk);
    axiRead(`BSF_OFS_ADDR, 32'h1ffff, 0, 2'h0, s);
    axiRead(`BSF_OFS_WDATA, 32'hff, 0, 2'h0, s);
    axiRead(`BSF_OFS_STATUS, 32'hffff, 0, 2'h0, s);
    axiRead(5'h10, 32'hffffffff, 0, 2'h2, s);
    axiWrite(5'h14, 32'h1, 2'h2);
    $display("test reset values done");
    repeat (4)
    begin
      v = $random(seed);
      axiWrite(`BSF_OFS_ADDR, v, 2'h0);
      axiRead(`BSF_OFS_ADDR, 32'h1ffff, v & 32'h1ffff, 2'h0, s);
    end
    $display("test address register done");
    v = $random(seed);
    pa = v[16:0];
    pd = v[24:17];
    progSeq(pa, pd);
    flashRd(pa, 8'h80, {~pd[7], 7'h0});
    do runOp(`BSF_OP_POLL, s); while (s[2]);
    flashRd(pa, 8'hff, pd);
    $display("test program done");
    v = $random(seed);
    pa = v[16:0];
    pd = v[24:17];
    progSeq(pa, pd);
    runOp(`BSF_OP_RESET, s);
    flashRd(pa, 8'hff, pd);
    $display("test reset abort done");
    summarize();
  end
endmodule // tb
`default_nettype wire
